// ===== include/joy_pkg.sv
// constants shared by the dual joystick port design
`default_nettype none

package joy_pkg;

  // ----------------------------------------------------------------
  // host I/O map
  // ----------------------------------------------------------------
  localparam logic [15:0] STATUS_OFS = 16'h0000;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ----------------------------------------------------------------
  // configuration space indices and resets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_ACTIVATE_IDX = 8'h30;
  localparam logic [7:0] CFG_BASE_HI_IDX = 8'h60;
  localparam logic [7:0] CFG_BASE_LO_IDX = 8'h61;
  localparam logic [7:0] CFG_PWR_CTRL_IDX = 8'h22;
  localparam int ACTIVATE_BIT = 0;
  localparam int PWR_JOY_BIT = 2;
  localparam logic [7:0] BASE_HI_RST = 8'h00;
  localparam logic [7:0] BASE_LO_RST = 8'h00;
  localparam logic [7:0] PWR_CTRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int AXES_LSB = 0;
  localparam int BUTTONS_LSB = 4;
  localparam int NUM_AXES = 4;
  localparam int NUM_BUTTONS = 4;

endpackage : joy_pkg

`default_nettype wire

// ===== core/joy_axis_timer.sv
// one axis one-shot timer: output bit and rc node discharge control
`default_nettype none

module joy_axis_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control from the port decoder
  input wire logic hold_i,
  input wire logic restart_i,
  // comparator: node has reached two thirds of reference
  input wire logic at_threshold_i,
  // timer output and discharge drive
  output logic timeout_o,
  output logic discharge_o
);

  typedef struct packed {
    logic timeout_r;
    logic discharge_r;
  } axis_state_t;

  axis_state_t st_r;
  axis_state_t st_nxt;

  // ----------------------------------------------------------------
  // one-shot behaviour
  // ----------------------------------------------------------------
  // node held low while idle or while a port write is active
  always_comb begin
    st_nxt = st_r;
    if (restart_i) begin
      st_nxt.timeout_r = 1'b1;
      st_nxt.discharge_r = 1'b0;
    end else if (hold_i) begin
      st_nxt.discharge_r = 1'b1;
    end else if (st_r.timeout_r && at_threshold_i) begin
      st_nxt.timeout_r = 1'b0;
      st_nxt.discharge_r = 1'b1;
    end else if (!st_r.timeout_r) begin
      st_nxt.discharge_r = 1'b1;
    end
  end

  // reset leaves output low and node discharged
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= '{timeout_r: 1'b0, discharge_r: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timeout_o = st_r.timeout_r;
  assign discharge_o = st_r.discharge_r;

endmodule : joy_axis_timer

`default_nettype wire

// ===== core/joy_cfg_regs.sv
// configuration bytes: base address, activate and power control mirror
`default_nettype none

module joy_cfg_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_index_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // decoded settings
  output logic [15:0] base_o,
  output logic active_o
);

  typedef struct packed {
    logic [7:0] base_hi_r;
    logic [7:0] base_lo_r;
    logic [7:0] pwr_other_r;
    logic active_r;
    logic [7:0] rdata_r;
  } cfg_state_t;

  cfg_state_t st_r;
  cfg_state_t st_nxt;

  // power control byte view with the mirrored joystick bit
  function automatic logic [7:0] pwr_view(input logic [7:0] other, input logic act);
    logic [7:0] v;
    v = other;
    v[joy_pkg::PWR_JOY_BIT] = act;
    return v;
  endfunction : pwr_view

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (cfg_wr_i) begin
      unique case (cfg_index_i)
        joy_pkg::CFG_BASE_HI_IDX: st_nxt.base_hi_r = cfg_wdata_i;
        joy_pkg::CFG_BASE_LO_IDX: st_nxt.base_lo_r = cfg_wdata_i;
        joy_pkg::CFG_ACTIVATE_IDX: begin
          st_nxt.active_r = cfg_wdata_i[joy_pkg::ACTIVATE_BIT];
        end
        joy_pkg::CFG_PWR_CTRL_IDX: begin
          st_nxt.pwr_other_r = cfg_wdata_i;
          st_nxt.active_r = cfg_wdata_i[joy_pkg::PWR_JOY_BIT];
        end
        default: ;
      endcase
    end
    // read data captured at the read, unknown index reads zero
    if (cfg_rd_i) begin
      unique case (cfg_index_i)
        joy_pkg::CFG_BASE_HI_IDX: st_nxt.rdata_r = st_r.base_hi_r;
        joy_pkg::CFG_BASE_LO_IDX: st_nxt.rdata_r = st_r.base_lo_r;
        joy_pkg::CFG_ACTIVATE_IDX: st_nxt.rdata_r = {7'h00, st_r.active_r};
        joy_pkg::CFG_PWR_CTRL_IDX: begin
          st_nxt.rdata_r = pwr_view(st_r.pwr_other_r, st_r.active_r);
        end
        default: st_nxt.rdata_r = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r.base_hi_r <= joy_pkg::BASE_HI_RST;
      st_r.base_lo_r <= joy_pkg::BASE_LO_RST;
      st_r.pwr_other_r <= joy_pkg::PWR_CTRL_RST;
      st_r.active_r <= 1'b0;
      st_r.rdata_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata_o = st_r.rdata_r;
  assign base_o = {st_r.base_hi_r, st_r.base_lo_r};
  assign active_o = st_r.active_r;

endmodule : joy_cfg_regs

`default_nettype wire

// ===== core/dual_joystick_port.sv
// dual joystick port: I/O decode, status byte and four axis timers
`default_nettype none

module dual_joystick_port (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // host system I/O cycle
  input wire logic [15:0] IO_ADDR_I,
  input wire logic IO_RD_I,
  input wire logic IO_WR_I,
  input wire logic [7:0] IO_WDATA_I,
  output logic [7:0] IO_RDATA_O,
  output logic IO_HIT_O,
  // configuration access
  input wire logic CFG_WR_I,
  input wire logic CFG_RD_I,
  input wire logic [7:0] CFG_INDEX_I,
  input wire logic [7:0] CFG_WDATA_I,
  output logic [7:0] CFG_RDATA_O,
  // joystick inputs: comparators and buttons
  input wire logic [3:0] AXIS_AT_THRESHOLD_I,
  input wire logic [3:0] BUTTON_I,
  // axis rc node discharge drive and active flag
  output logic [3:0] AXIS_RC_NODE_O,
  output logic [3:0] AXIS_RC_NODE_OE_O,
  output logic ACTIVE_O
);

  typedef struct packed {
    logic wr_hit_r;
    logic [3:0] button_r;
    logic [7:0] rdata_r;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic [15:0] base;
  logic active;
  logic rd_hit;
  logic wr_hit;
  logic restart;
  logic [3:0] axis_timeout;
  logic [3:0] discharge;
  logic [7:0] status;

  // address match, only while the logical device is active
  function automatic logic port_match(input logic [15:0] addr, input logic [15:0] bse,
                                      input logic act);
    return act && (addr == (bse + joy_pkg::STATUS_OFS));
  endfunction : port_match

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  joy_cfg_regs u_cfg (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .cfg_wr_i(CFG_WR_I),
    .cfg_rd_i(CFG_RD_I),
    .cfg_index_i(CFG_INDEX_I),
    .cfg_wdata_i(CFG_WDATA_I),
    .cfg_rdata_o(CFG_RDATA_O),
    .base_o(base),
    .active_o(active)
  );

  // ----------------------------------------------------------------
  // host cycle decode
  // ----------------------------------------------------------------
  // write data is never looked at: only the cycle itself matters
  assign rd_hit = IO_RD_I && port_match(IO_ADDR_I, base, active);
  assign wr_hit = IO_WR_I && port_match(IO_ADDR_I, base, active);
  // trailing edge of the decoded write strobe restarts timing
  assign restart = st_r.wr_hit_r && !wr_hit;
  assign IO_HIT_O = rd_hit || wr_hit;

  // ----------------------------------------------------------------
  // axis timers, one per axis
  // ----------------------------------------------------------------
  for (genvar i = 0; i < joy_pkg::NUM_AXES; i++) begin : g_axis
    joy_axis_timer u_axis (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .hold_i(wr_hit),
      .restart_i(restart),
      .at_threshold_i(AXIS_AT_THRESHOLD_I[i]),
      .timeout_o(axis_timeout[i]),
      .discharge_o(discharge[i])
    );
  end

  // rc node driven low only while discharging, else released
  assign AXIS_RC_NODE_O = 4'h0;
  assign AXIS_RC_NODE_OE_O = discharge;

  // ----------------------------------------------------------------
  // status byte and read path
  // ----------------------------------------------------------------
  // buttons {s2b2,s2b1,s1b2,s1b1}, axes {s2y,s2x,s1y,s1x}
  always_comb begin
    status = joy_pkg::STATUS_RST;
    status[joy_pkg::BUTTONS_LSB +: joy_pkg::NUM_BUTTONS] = st_r.button_r;
    status[joy_pkg::AXES_LSB +: joy_pkg::NUM_AXES] = axis_timeout;
  end

  // write data never enters the byte; it is live state only
  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_hit_r = wr_hit;
    st_nxt.button_r = BUTTON_I;
    if (rd_hit) begin
      st_nxt.rdata_r = status;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      st_r.wr_hit_r <= 1'b0;
      st_r.button_r <= 4'h0;
      st_r.rdata_r <= joy_pkg::STATUS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign IO_RDATA_O = st_r.rdata_r;
  assign ACTIVE_O = active;

endmodule : dual_joystick_port

`default_nettype wire

// ===== verification/dual_joystick_port_checker.sv
// pin-level assertions for the dual joystick port
`default_nettype none
module dual_joystick_port_checker (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // host I/O and joystick pins
  input wire logic IO_RD_I,
  input wire logic IO_WR_I,
  input wire logic IO_HIT_O,
  input wire logic [7:0] IO_RDATA_O,
  input wire logic [3:0] AXIS_AT_THRESHOLD_I,
  input wire logic [3:0] BUTTON_I,
  input wire logic [3:0] AXIS_RC_NODE_O,
  input wire logic [3:0] AXIS_RC_NODE_OE_O,
  input wire logic ACTIVE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // -----------------------------------------------------------------
  // write cycle steps
  // -----------------------------------------------------------------
  sequence wr_hit;
    IO_HIT_O && IO_WR_I;
  endsequence
  sequence wr_end;
    wr_hit ##1 !(IO_HIT_O && IO_WR_I);
  endsequence
  a_hit_needs_strobe: assert property (IO_HIT_O |-> IO_RD_I || IO_WR_I)
    else $error("hit without a strobe");
  a_idle_no_hit: assert property (!ACTIVE_O |-> !IO_HIT_O)
    else $error("decode while inactive");
  a_write_holds_discharge: assert property (wr_hit |=> AXIS_RC_NODE_OE_O == 4'hf)
    else $error("nodes not discharged during write");
  a_trailing_restart: assert property (wr_end |=> AXIS_RC_NODE_OE_O == 4'h0)
    else $error("no restart on strobe release");
  a_threshold_discharge: assert property (
      !AXIS_RC_NODE_OE_O[0] && AXIS_AT_THRESHOLD_I[0] && !(IO_HIT_O && IO_WR_I)
      |=> AXIS_RC_NODE_OE_O[0])
    else $error("threshold did not discharge node");
  a_node_driven_low: assert property (AXIS_RC_NODE_O == 4'h0)
    else $error("node drive not low");
  a_read_buttons: assert property (
      IO_HIT_O && IO_RD_I |=> IO_RDATA_O[7:4] == $past(BUTTON_I, 2))
    else $error("button bits wrong");
  a_rdata_holds: assert property (!(IO_HIT_O && IO_RD_I) |=> $stable(IO_RDATA_O))
    else $error("read data changed without read");
endmodule : dual_joystick_port_checker
bind dual_joystick_port dual_joystick_port_checker i_dual_joystick_port_checker (.CLK_I,
  .RESET_I, .IO_RD_I, .IO_WR_I, .IO_HIT_O, .IO_RDATA_O, .AXIS_AT_THRESHOLD_I, .BUTTON_I,
  .AXIS_RC_NODE_O, .AXIS_RC_NODE_OE_O, .ACTIVE_O);
`default_nettype wire

// ===== verification/joy_rc_model.sv
// far-side rc network: each node charges while released
`default_nettype none
module joy_rc_model #(
  parameter int BASE = 4
) (
  input wire logic clk_i,
  input wire logic [3:0] discharge_i,
  output logic [3:0] at_threshold_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [4] = '{default: 0};
  logic [3:0] thr_r = 4'h0;
  // axis i is slower by three cycles, so axes time out in order
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= discharge_i[i] ? 0 : cnt[i] + 1;
      thr_r[i] <= !discharge_i[i] && cnt[i] >= BASE + 3 * i;
    end
  end
  assign at_threshold_o = thr_r;
endmodule : joy_rc_model
`default_nettype wire

// ===== verification/test_dual_joystick_port.sv
// self-checking bench for the dual joystick port
`default_nettype none
module test_dual_joystick_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, cwr = 1'b0, crd = 1'b0, hit, act;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, cidx = 8'h00, cwd = 8'h00, rdata, crdata;
  logic [3:0] btn = 4'ha, thr, oe, node;
  int num_errors = 0, n_compared = 0, polls;
  dual_joystick_port i_dual_joystick_port (.CLK_I(clk), .RESET_I(rst), .IO_ADDR_I(addr),
    .IO_RD_I(rd), .IO_WR_I(wr), .IO_WDATA_I(wdata), .IO_RDATA_O(rdata), .IO_HIT_O(hit),
    .CFG_WR_I(cwr), .CFG_RD_I(crd), .CFG_INDEX_I(cidx), .CFG_WDATA_I(cwd),
    .CFG_RDATA_O(crdata), .AXIS_AT_THRESHOLD_I(thr), .BUTTON_I(btn),
    .AXIS_RC_NODE_O(node), .AXIS_RC_NODE_OE_O(oe), .ACTIVE_O(act));
  joy_rc_model i_joy_rc_model (.clk_i(clk), .discharge_i(oe), .at_threshold_o(thr));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // host I/O cycle held n edges; hit is judged while the strobe stands
  task automatic io(input logic w, input logic [15:0] a, input int n, input logic h);
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= 8'h5a;
    #1 chk({7'h00, hit}, {7'h00, h});
    repeat (n) @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
  endtask : io
  task automatic cfg(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    cwr <= w;
    crd <= !w;
    cidx <= i;
    cwd <= d;
    @(posedge clk);
    cwr <= 1'b0;
    crd <= 1'b0;
    #1;
  endtask : cfg
  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    io(1'b0, 16'h0000, 1, 1'b0);
    chk(rdata, 8'h00);
    chk({4'h0, oe | node}, 8'h0f);
    io(1'b1, 16'h0000, 1, 1'b0);
    cfg(1'b1, 8'h60, 8'h02);
    cfg(1'b1, 8'h61, 8'h01);
    cfg(1'b0, 8'h60, 8'h00);
    chk(crdata, 8'h02);
    cfg(1'b1, 8'h22, 8'h04);
    chk({7'h00, act}, 8'h01);
    cfg(1'b0, 8'h30, 8'h00);
    chk(crdata, 8'h01);
    cfg(1'b1, 8'h30, 8'h00);
    cfg(1'b0, 8'h22, 8'h00);
    chk(crdata, 8'h00);
    cfg(1'b1, 8'h30, 8'h01);
    cfg(1'b0, 8'h31, 8'h00); // unmapped index
    chk(crdata, 8'h00); // unmapped index
    io(1'b0, 16'h0202, 1, 1'b0);
    io(1'b0, 16'h0201, 1, 1'b1);
    chk(rdata, 8'ha0);
    io(1'b1, 16'h0201, 3, 1'b1);
    chk({4'h0, oe}, 8'h0f);
    @(posedge clk);
    btn <= 4'h5;
    #1 chk({4'h0, oe}, 8'h00);
    io(1'b0, 16'h0201, 1, 1'b1);
    chk(rdata, 8'h5f);
    // host polls until every axis has timed out; bounded, a hang counts as a mismatch
    polls = 0;
    do begin
      io(1'b0, 16'h0201, 1, 1'b1);
      polls++;
      chk({7'h00, rdata[3:0] inside {4'hf, 4'he, 4'hc, 4'h8, 4'h0}}, 8'h01);
    end while (rdata[3:0] !== 4'h0 && polls < 50);
    if (rdata[3:0] !== 4'h0) begin
      num_errors++;
      $display("ERROR %0t: axes never timed out", $time);
    end
    chk(rdata, 8'h50);
    chk({4'h0, oe}, 8'h0f);
    cfg(1'b1, 8'h22, 8'h00);
    io(1'b1, 16'h0201, 1, 1'b0);
    @(posedge clk);
    #1 chk({4'h0, oe}, 8'h0f);
    // mid-run reset: status, activate and base return to their reset values
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(rdata, 8'h00);
    chk({7'h00, act}, 8'h00);
    chk({4'h0, oe}, 8'h0f);
    cfg(1'b1, 8'h30, 8'h01);
    io(1'b0, 16'h0201, 1, 1'b0);
    complete_run();
  end
endmodule : test_dual_joystick_port
`default_nettype wire
